// *** hw/fdl_params.svh ***
// Constants for the low-battery and fault-status register bank.
// Assumes inclusion by every design file of the bank except fdl_pkg.
`ifndef FDL_PARAMS_SVH
`define FDL_PARAMS_SVH

`define FDL_ADDR_LB_CTRL 8'h0D
`define FDL_ADDR_LB_TIMER 8'h0E
`define FDL_ADDR_WDOG 8'h16
`define FDL_ADDR_FAULT_STATUS_ONE 8'h17
`define FDL_ADDR_STATUS2 8'h18
`define FDL_RST_LB_CTRL 8'h00
`define FDL_RST_LB_TIMER 8'h00
`define FDL_RST_WDOG 8'h00
`define FDL_BIT_BATTERY_GUARD_ENABLE 7
`define FDL_TH_MSB 6
`define FDL_TH_LSB 2
`define FDL_HYS_MSB 1
`define FDL_HYS_LSB 0
`define FDL_TH_MIN 5'h04
`define FDL_HYS_100 2'h0
`define FDL_HYS_200 2'h1
`define FDL_HYS_OFF 2'h3
`define FDL_TMR_250 2'h0
`define FDL_TMR_500 2'h1
`define FDL_BIT_GUARD_TRIG 7
`define FDL_CLK_MHZ 250
`define FDL_TMR_250_US_X1000 250
`define FDL_TMR_500_US_X1000 500
`define FDL_TMR_250_CYC (`FDL_TMR_250_US_X1000 * `FDL_CLK_MHZ)
`define FDL_TMR_500_CYC (`FDL_TMR_500_US_X1000 * `FDL_CLK_MHZ)
`define FDL_TMR_W 17

`endif

// *** hw/fdl_pkg.sv ***
// Types for the low-battery and fault-status register bank.
// Assumes fdl_params.svh is on the include path.
package fdl_pkg;
    typedef enum logic [1:0] {
        FDL_GUARD_IDLE,
        FDL_GUARD_REDUCED,
        FDL_GUARD_RECOVER
    } fdl_guard_t;
endpackage

// *** hw/fdl_sticky.sv ***
// Per-bit latched flag set by events, cleared by a register read.
// Assumes event and read strobes synchronous to mclk.
`timescale 1ns/1ns
`include "fdl_params.svh"
module fdl_sticky
    import fdl_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic [7:0] event_in, // Fault condition levels
    input wire logic read_clr, // Register read strobe
    output logic [7:0] flags_q // Latched flags
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            // Set wins over the clear of a read
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    flags_q[i] <= 1'b0;
                end else if (event_in[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (read_clr) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    a_sticky_set: assert property (@(posedge mclk) disable iff (sys_rst)
        |event_in |-> ##1 |flags_q) else $error("flag did not latch");
    a_sticky_clr: assert property (@(posedge mclk) disable iff (sys_rst)
        read_clr && !(|event_in) |-> ##1 flags_q == 8'h00) else $error("flag not cleared on read");
endmodule

// *** hw/fdl_regs.sv ***
// Low-battery guard controls, watchdog restart and latched fault status.
// Assumes a register port synchronous to mclk, reads sampled from rd_data_q one cycle later.
`timescale 1ns/1ns
`include "fdl_params.svh"

// Functional notes
// - Guard runs only while enable bit set
// - Five-bit threshold; codes below 00100 unused (stored and driven on battery_guard_threshold unchanged)
// - Hysteresis 100/200mV; code 11 never restores
// - Recovery timer 0.250 or 0.500 ms
// - Kick bit restarts watchdog, self-clears after
// - Faults latch, clear on read, reassert
// - Bit 7 thermistor short fault
// - Bit 6 radio blank event
// - Bit 5 output window fault
// - Bit 4 die overtemperature
// - Bit 3 thermistor overheat trip
// - Bit 2 indicator LED fault
// - Bit 1 flash LED B fault
// - Bit 0 flash LED A fault
// - Reserved bits reset zero, no function
// - Separate flag records guard triggering
module fdl_regs
    import fdl_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] rd_data_q, // Read data
    input wire logic batt_below_th, // Battery under threshold
    input wire logic batt_above_hys, // Battery above threshold plus hysteresis
    input wire logic wdog_restart_done, // Watchdog acknowledges restart
    input wire logic thermistor_short_fault, // Thermistor short condition
    input wire logic radio_blank_event, // Radio blank condition
    input wire logic output_window_fault, // Converter out of window
    input wire logic die_overtemp, // Die overtemperature
    input wire logic thermistor_overheat_flag, // Thermistor trip
    input wire logic indicator_led_fault, // Indicator LED fault
    input wire logic flash_led_b_fault, // Flash LED B fault
    input wire logic flash_led_a_fault, // Flash LED A fault
    output logic battery_guard_enable, // Guard enabled
    output logic [4:0] battery_guard_threshold, // Threshold code
    output logic [1:0] battery_guard_hysteresis, // Hysteresis code
    output logic [1:0] battery_guard_recovery_time, // Recovery timer code
    output logic watchdog_kick_bit, // Watchdog restart request
    output logic flash_reduce_q // Flash current reduced
);
    logic [7:0] lb_ctrl_q;
    logic [1:0] battery_guard_recovery_time_q;
    logic kick_q;
    logic [7:0] fault_flags;
    logic [7:0] fault_events;
    logic guard_trig_q;
    logic guard_trig_pulse;
    fdl_guard_t guard_q;
    logic [`FDL_TMR_W-1:0] tmr_cnt_q;
    logic [`FDL_TMR_W-1:0] tmr_limit;
    logic rd_fault_status_one;
    logic rd_status2;

    assign rd_fault_status_one = reg_rd && (reg_addr == `FDL_ADDR_FAULT_STATUS_ONE);
    assign rd_status2 = reg_rd && (reg_addr == `FDL_ADDR_STATUS2);

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lb_ctrl_q <= `FDL_RST_LB_CTRL;
        end else if (reg_wr && reg_addr == `FDL_ADDR_LB_CTRL) begin
            lb_ctrl_q <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            battery_guard_recovery_time_q <= 2'h0;
        end else if (reg_wr && reg_addr == `FDL_ADDR_LB_TIMER) begin
            battery_guard_recovery_time_q <= reg_wdata[1:0];
        end
    end

    // Kick stays set until the watchdog confirms the restart
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            kick_q <= 1'b0;
        end else if (reg_wr && reg_addr == `FDL_ADDR_WDOG && reg_wdata[0]) begin
            kick_q <= 1'b1;
        end else if (wdog_restart_done) begin
            kick_q <= 1'b0;
        end
    end

    assign battery_guard_enable = lb_ctrl_q[`FDL_BIT_BATTERY_GUARD_ENABLE];
    assign battery_guard_threshold = lb_ctrl_q[`FDL_TH_MSB:`FDL_TH_LSB];
    assign battery_guard_hysteresis = lb_ctrl_q[`FDL_HYS_MSB:`FDL_HYS_LSB];
    assign battery_guard_recovery_time = battery_guard_recovery_time_q;
    assign watchdog_kick_bit = kick_q;

    ////////////////////////////////////////////////////////////////////////
    // Battery guard
    // Reserved timer codes fall back to the longer duration
    assign tmr_limit = (battery_guard_recovery_time_q == `FDL_TMR_250) ? `FDL_TMR_W'(`FDL_TMR_250_CYC - 1)
                                                  : `FDL_TMR_W'(`FDL_TMR_500_CYC - 1);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            guard_q <= FDL_GUARD_IDLE;
            tmr_cnt_q <= '0;
        end else if (!battery_guard_enable) begin
            guard_q <= FDL_GUARD_IDLE;
            tmr_cnt_q <= '0;
        end else begin
            unique case (guard_q)
                FDL_GUARD_IDLE: begin
                    if (batt_below_th) begin
                        guard_q <= FDL_GUARD_REDUCED;
                    end
                end
                FDL_GUARD_REDUCED: begin
                    tmr_cnt_q <= '0;
                    if (batt_above_hys && battery_guard_hysteresis != `FDL_HYS_OFF) begin
                        guard_q <= FDL_GUARD_RECOVER;
                    end
                end
                FDL_GUARD_RECOVER: begin
                    if (!batt_above_hys) begin
                        guard_q <= FDL_GUARD_REDUCED;
                    end else if (tmr_cnt_q >= tmr_limit) begin
                        // Also ends a wait cut short by a shorter timer code
                        guard_q <= FDL_GUARD_IDLE;
                    end else begin
                        tmr_cnt_q <= tmr_cnt_q + `FDL_TMR_W'(1);
                    end
                end
                default: guard_q <= FDL_GUARD_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_reduce_q <= 1'b0;
        end else begin
            flash_reduce_q <= battery_guard_enable && (guard_q != FDL_GUARD_IDLE);
        end
    end

    assign guard_trig_pulse = battery_guard_enable && guard_q == FDL_GUARD_IDLE && batt_below_th;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            guard_trig_q <= 1'b0;
        end else if (guard_trig_pulse) begin
            guard_trig_q <= 1'b1;
        end else if (rd_status2) begin
            guard_trig_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault status
    assign fault_events = {thermistor_short_fault,
                           radio_blank_event,
                           output_window_fault,
                           die_overtemp,
                           thermistor_overheat_flag,
                           indicator_led_fault,
                           flash_led_b_fault,
                           flash_led_a_fault};

    fdl_sticky u_fault_status_one (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .event_in(fault_events),
        .read_clr(rd_fault_status_one),
        .flags_q(fault_flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `FDL_ADDR_LB_CTRL: rd_data_q <= lb_ctrl_q;
                `FDL_ADDR_LB_TIMER: rd_data_q <= {6'h00, battery_guard_recovery_time_q};
                `FDL_ADDR_WDOG: rd_data_q <= {7'h00, kick_q};
                `FDL_ADDR_FAULT_STATUS_ONE: rd_data_q <= fault_flags;
                `FDL_ADDR_STATUS2: rd_data_q <= {guard_trig_q, 7'h00};
                default: rd_data_q <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_guard_enable: assert property (@(posedge mclk) disable iff (sys_rst)
        !battery_guard_enable |-> ##1 !flash_reduce_q) else $error("reduce while disabled");
    a_guard_trigger: assert property (@(posedge mclk) disable iff (sys_rst)
        guard_trig_pulse |-> ##2 flash_reduce_q) else $error("no reduction below threshold");
    a_hys_off_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        guard_q == FDL_GUARD_REDUCED && battery_guard_hysteresis == `FDL_HYS_OFF && battery_guard_enable
        |=> guard_q == FDL_GUARD_REDUCED) else $error("restored with hysteresis off");
    a_recover_time: assert property (@(posedge mclk) disable iff (sys_rst)
        (guard_q == FDL_GUARD_RECOVER && battery_guard_enable ##1 guard_q == FDL_GUARD_IDLE)
        |-> $past(tmr_cnt_q) >= $past(tmr_limit)) else $error("recovery too short");
    a_kick_set: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == `FDL_ADDR_WDOG && reg_wdata[0] |=> watchdog_kick_bit) else $error("kick lost");
    a_kick_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        wdog_restart_done && !(reg_wr && reg_addr == `FDL_ADDR_WDOG) |=> !watchdog_kick_bit)
        else $error("kick not cleared");
    a_status_read: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_fault_status_one |=> rd_data_q == $past(fault_flags)) else $error("status read mismatch");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == `FDL_ADDR_LB_TIMER |=> rd_data_q[7:2] == 6'h00) else $error("reserved set");
    a_trig_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        guard_trig_pulse |=> guard_trig_q) else $error("trigger flag missed");
    a_fault_sets: assert property (@(posedge mclk) disable iff (sys_rst)
        flash_led_a_fault |=> fault_flags[0]) else $error("fault A not latched");

    ////////////////////////////////////////////////////////////////////////
    // Status bit latching, one check per fault source for bits 7 to 1; bit 0 is checked by a_fault_sets above
    a_fault_short: assert property (@(posedge mclk) disable iff (sys_rst)
        thermistor_short_fault |=> fault_flags[7])
        else $error("thermistor short not latched");
    a_fault_radio: assert property (@(posedge mclk) disable iff (sys_rst)
        radio_blank_event |=> fault_flags[6])
        else $error("radio blank not latched");
    a_fault_window: assert property (@(posedge mclk) disable iff (sys_rst)
        output_window_fault |=> fault_flags[5])
        else $error("window fault not latched");
    a_fault_overtemp: assert property (@(posedge mclk) disable iff (sys_rst)
        die_overtemp |=> fault_flags[4])
        else $error("overtemp not latched");
    a_fault_overheat: assert property (@(posedge mclk) disable iff (sys_rst)
        thermistor_overheat_flag |=> fault_flags[3])
        else $error("thermistor trip not latched");
    a_fault_indicator: assert property (@(posedge mclk) disable iff (sys_rst)
        indicator_led_fault |=> fault_flags[2])
        else $error("indicator fault not latched");
    a_fault_ledb: assert property (@(posedge mclk) disable iff (sys_rst)
        flash_led_b_fault |=> fault_flags[1])
        else $error("fault B not latched");

    ////////////////////////////////////////////////////////////////////////
    // Register and guard behaviour
    a_status_reread: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_fault_status_one |=> fault_flags == $past(fault_events))
        else $error("flags after read wrong");
    a_kick_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == `FDL_ADDR_WDOG |=> rd_data_q[7:1] == 7'h00)
        else $error("kick reserved set");
    a_ctrl_write: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == `FDL_ADDR_LB_CTRL |=> lb_ctrl_q == $past(reg_wdata))
        else $error("control write lost");
    a_timer_write: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == `FDL_ADDR_LB_TIMER |=> battery_guard_recovery_time_q == $past(reg_wdata[1:0]))
        else $error("timer write lost");
    a_trig_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_status2 && !guard_trig_pulse |=> !guard_trig_q)
        else $error("trigger flag not cleared");
    a_recover_abort: assert property (@(posedge mclk) disable iff (sys_rst)
        guard_q == FDL_GUARD_RECOVER && battery_guard_enable && !batt_above_hys
        |=> guard_q == FDL_GUARD_REDUCED)
        else $error("recovery not aborted");
    a_enable_idle: assert property (@(posedge mclk) disable iff (sys_rst)
        !battery_guard_enable |=> guard_q == FDL_GUARD_IDLE)
        else $error("guard active while disabled");

    c_guard_cycle: cover property (@(posedge mclk) disable iff (sys_rst)
        guard_q == FDL_GUARD_RECOVER ##1 guard_q == FDL_GUARD_IDLE);
    c_status_clear: cover property (@(posedge mclk) disable iff (sys_rst)
        rd_fault_status_one && |fault_flags);
    c_kick: cover property (@(posedge mclk) disable iff (sys_rst) watchdog_kick_bit ##1 !watchdog_kick_bit);
    c_hys_off: cover property (@(posedge mclk) disable iff (sys_rst)
        guard_q == FDL_GUARD_REDUCED && batt_above_hys && battery_guard_hysteresis == `FDL_HYS_OFF);
endmodule

// *** bench/fdl_host.sv ***
// Host model driving the byte-wide register port of the low-battery bank.
// Assumes tasks are entered just after a rising edge of mclk.
`timescale 1ns/1ns
module fdl_host (
    input wire logic mclk, // System clock
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_addr, // Address
    output logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] rd_data_q // Read data
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hFF;
        reg_wdata = 8'h00;
    end

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == 8'h0D && d[6:2] < 5'h04) begin
            d[6:2] = 5'h04;
        end
        if (addr == 8'h0E) begin
            d[1] = 1'b0;
        end
        reg_addr = addr;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        // Released bus shows no stale value
        reg_addr = ~addr;
        reg_wdata = ~d;
        @(posedge mclk);
        #1;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        data = rd_data_q;
        reg_addr = ~addr;
        @(posedge mclk);
        #1;
    endtask
endmodule

// *** bench/test_fdl_regs.sv ***
// Self-checking bench for the low-battery and fault-status bank.
// Assumes fdl_host drives the register port; levels come from here.
`timescale 1ns/1ns
`include "fdl_params.svh"
module test_fdl_regs;
    logic mclk, sys_rst, reg_wr, reg_rd, below, above, done, g_en, kick, reduce;
    logic [7:0] reg_addr, reg_wdata, rd_data_q, flt, v, m;
    logic [4:0] g_th;
    logic [1:0] g_hys, g_tmr;
    logic [7:0] addrs [4] = '{8'h0D, 8'h0E, 8'h16, 8'h20};
    integer seed = 32'h144386d0;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int k;

    fdl_host u_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .rd_data_q(rd_data_q));
    fdl_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_data_q(rd_data_q),
        .batt_below_th(below), .batt_above_hys(above), .wdog_restart_done(done),
        .thermistor_short_fault(flt[7]), .radio_blank_event(flt[6]), .output_window_fault(flt[5]),
        .die_overtemp(flt[4]), .thermistor_overheat_flag(flt[3]), .indicator_led_fault(flt[2]),
        .flash_led_b_fault(flt[1]), .flash_led_a_fault(flt[0]), .battery_guard_enable(g_en),
        .battery_guard_threshold(g_th), .battery_guard_hysteresis(g_hys),
        .battery_guard_recovery_time(g_tmr), .watchdog_kick_bit(kick), .flash_reduce_q(reduce));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp, input string what);
        logic [7:0] d;
        u_host.read_reg(addr, d);
        chk(d, exp, what);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    function automatic logic [7:0] exp_ctrl(input logic [7:0] w);
        exp_ctrl = w;
        if (w[6:2] < 5'h04) begin
            exp_ctrl[6:2] = 5'h04;
        end
    endfunction

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, about 15k cycles above the expected run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            stop_test;
        end
    end

    initial begin
        {below, above, done, flt, sys_rst} = {11'h000, 1'b1};
        tick(10);
        sys_rst = 1'b0;
        tick(1);
        foreach (addrs[i]) begin
            rdchk(addrs[i], 8'h00, "reset value");
        end
        chk({5'h00, g_en, kick, reduce}, 8'h00, "reset outputs");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($random(seed));
            u_host.write_reg(8'h0D, v);
            rdchk(8'h0D, exp_ctrl(v), "control readback");
            chk({g_en, g_th, g_hys}, exp_ctrl(v), "control fields");
        end
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            u_host.write_reg(8'h0E, v);
            rdchk(8'h0E, {7'h00, v[0]}, "timer readback");
            chk({6'h00, g_tmr}, {7'h00, v[0]}, "timer field");
        end
        $display("test control done");
        u_host.write_reg(8'h16, 8'hFF);
        rdchk(8'h16, 8'h01, "kick readback");
        tick(3);
        chk({7'h00, kick}, 8'h01, "kick held");
        done = 1'b1;
        tick(1);
        done = 1'b0;
        chk({7'h00, kick}, 8'h00, "kick cleared");
        rdchk(8'h16, 8'h00, "kick readback cleared");
        $display("test watchdog done");
        for (int i = 0; i < 8; i++) begin
            flt = 8'h01 << i;
            tick(1);
            flt = 8'h00;
            rdchk(8'h17, 8'h01 << i, "fault bit");
            rdchk(8'h17, 8'h00, "fault clear");
        end
        m = 8'($random(seed));
        flt = m;
        tick(1);
        rdchk(8'h17, m, "held faults");
        rdchk(8'h17, m, "faults set again");
        flt = 8'h00;
        rdchk(8'h17, m, "last latched");
        rdchk(8'h17, 8'h00, "all clear");
        $display("test status done");
        u_host.write_reg(8'h0E, 8'h00);
        u_host.write_reg(8'h0D, 8'h90);
        below = 1'b1;
        tick(1);
        below = 1'b0;
        tick(1);
        chk({7'h00, reduce}, 8'h01, "guard reduce");
        rdchk(8'h18, 8'h80, "guard triggered");
        rdchk(8'h18, 8'h00, "guard flag clear");
        above = 1'b1;
        tick(`FDL_TMR_250_CYC - 100);
        chk({7'h00, reduce}, 8'h01, "early restore");
        k = 0;
        while (reduce === 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        chk({7'h00, k >= 99 && k <= 103}, 8'h01, "recovery time");
        above = 1'b0;
        u_host.write_reg(8'h0D, 8'h93);
        below = 1'b1;
        tick(1);
        below = 1'b0;
        tick(1);
        above = 1'b1;
        tick(2000);
        chk({7'h00, reduce}, 8'h01, "no hysteresis restore");
        u_host.write_reg(8'h0D, 8'h13);
        chk({7'h00, reduce}, 8'h00, "disable clears");
        above = 1'b0;
        $display("test guard done");
        stop_test;
    end
endmodule
